// ===== rcso_top.sv
// reset cause bookkeeping, watchdog service, debug reset and write-once options
//
// Operation
// R1: read-only status register with seven flags naming the last reset cause
// R2: a debug-host forced reset leaves every status flag cleared
// R3: any status write restarts the watchdog, flags stay unchanged
// R4: power-on reset sets power-on and brownout flags, clears the rest
// R5: brownout reset keeps power-on flag, sets brownout, clears the rest
// R6: other resets set flags of sources active at reset, clear the rest
// R7: pin flag set when reset came from low external reset input
// R8: watchdog flag on watchdog timeout; no such reset while watchdog disabled
// R9: bad opcode flag on unimplemented opcode, disallowed stop or background instruction
// R10: access in gap after ram causes reset and sets bad address flag
// R11: gap before flash also illegal; register locations never trigger it
// R12: clock module flag set when clock generator requested the reset
// R13: brownout reset only with both brownout enables set and supply tripped
// R14: debug force register ignores cpu writes, takes debug writes, reads zero
// R15: debug write of one to bit zero forces a full device reset
// R16: debug host uses a background memory write to set the reset bit
// R17: option register always readable, bits three and two read zero
// R18: option register takes only first write after each reset
// R19: startup software should write the option register once to lock it
// R20: watchdog enable resets to one; one lets timeout force reset
// R21: long timeout select resets to one; zero picks short period
// R22: stop allow resets to zero; stop while zero forces bad opcode reset
// R23: flags captured during reset, held against writes until next reset
`timescale 1ns/1ps
module rcso_top #(
  parameter int HOLD_CYCLES = rcso_pkg::HOLD_CYCLES
) (
  input  wire logic        i_clock,
  input  wire logic        i_reset,
  // cpu register bus
  input  wire logic        i_cpu_valid,
  input  wire logic        i_cpu_write,
  input  wire logic [15:0] i_cpu_addr,
  input  wire logic [7:0]  i_cpu_wdata,
  output logic      [7:0]  o_cpu_rdata,
  output logic             o_cpu_hit,
  // background debug write port
  input  wire logic        i_debug_write,
  input  wire logic [15:0] i_debug_addr,
  input  wire logic [7:0]  i_debug_wdata,
  // reset sources
  input  wire logic        i_reset_pin_n,
  input  wire logic        i_watchdog_timeout,
  input  wire logic        i_unimpl_opcode,
  input  wire logic        i_stop_instr,
  input  wire logic        i_enter_background_instr,
  input  wire logic        i_background_mode_allow,
  input  wire logic        i_clock_gen_reset,
  input  wire logic        i_brownout_trip,
  input  wire logic        i_brownout_reset_enable,
  input  wire logic        i_brownout_stop_enable,
  // controls toward the rest of the device
  output logic             o_system_reset,
  output logic             o_watchdog_restart,
  output logic             o_watchdog_enable,
  output logic             o_watchdog_long_timeout,
  output logic             o_stop_allow
);

  // the hold counter is eight bits wide; longer holds need a wider counter
  if (HOLD_CYCLES < 1 || HOLD_CYCLES > 255) begin : g_hold_check
    $error("rcso_top: HOLD_CYCLES must be 1 to 255");
  end

  // last counter value of the minimum hold
  localparam logic [7:0] HOLD_LAST = 8'(HOLD_CYCLES - 1);

  // sequencer, status and bus-side state
  rcso_pkg::rcso_state_t state_r;
  rcso_pkg::rcso_state_t state_nxt;
  logic [7:0]            hold_cnt_r;
  logic [7:0]            hold_cnt_nxt;
  logic [7:0]            status_r;
  logic [7:0]            status_nxt;
  logic [7:0]            rdata_r;
  logic [7:0]            rdata_nxt;
  logic                  hit_r;
  logic                  hit_nxt;
  logic                  restart_r;
  logic                  restart_nxt;
  logic                  debug_force_r;
  logic                  debug_force_nxt;

  // decode and qualified source nets
  logic                  in_run;
  logic                  cpu_wr;
  logic                  cpu_rd;
  logic                  option_wr;
  logic [7:0]            option_value;
  logic                  bad_addr;
  logic                  src_pin;
  logic                  src_watchdog;
  logic                  src_opcode;
  logic                  src_clock_gen;
  logic                  src_brownout;
  logic                  any_source;
  logic [7:0]            active_flags;
  logic                  dbg_wr;
  logic                  cpu_status_wr;
  logic                  dbg_status_wr;
  logic                  cpu_option_wr;
  logic                  dbg_option_wr;
  logic                  dbg_force_wr;
  logic [7:0]            option_wdata;

  assign in_run = (state_r == rcso_pkg::RCSO_RUN);
  // cpu accesses are ignored while the device is held in reset
  assign cpu_wr = in_run && i_cpu_valid && i_cpu_write;
  assign cpu_rd = in_run && i_cpu_valid && !i_cpu_write;
  // debug writes are dropped during reset as well
  assign dbg_wr = in_run && i_debug_write;

  // write decode per port; the force address is decoded on the debug
  // port only, so user code can never reach it
  assign cpu_status_wr = cpu_wr && (i_cpu_addr == rcso_pkg::STATUS_ADDR);
  assign dbg_status_wr = dbg_wr && (i_debug_addr == rcso_pkg::STATUS_ADDR);
  assign cpu_option_wr = cpu_wr && (i_cpu_addr == rcso_pkg::OPTION_ADDR);
  assign dbg_option_wr = dbg_wr && (i_debug_addr == rcso_pkg::OPTION_ADDR);
  assign dbg_force_wr  = dbg_wr && (i_debug_addr == rcso_pkg::DEBUG_ADDR);

  // debug writes to the option register are honoured like cpu writes;
  // debug data wins only when it targets the option register itself,
  // so a debug write elsewhere cannot steal the cpu's option data
  assign option_wr    = cpu_option_wr || dbg_option_wr;
  assign option_wdata = dbg_option_wr ? i_debug_wdata : i_cpu_wdata;

  // write-once options, unlocked again by each reset
  rcso_once_reg #(
    .WIDTH     (8),
    .RESET_VAL (rcso_pkg::OPTION_RESET)
  ) u_options (
    .i_clock     (i_clock),
    .i_reset     (i_reset),
    .i_sys_reset (o_system_reset),
    .i_wr        (option_wr),                    // see R18
    .i_wdata     (option_wdata),
    .o_value     (option_value),
    .o_locked    ()
  );

  // gap detector on the cpu address bus; it is registered, so the
  // illegal address reset follows the access by two edges
  rcso_addr_guard u_addr_guard (
    .i_clock (i_clock),
    .i_reset (i_reset),
    .i_valid (in_run && i_cpu_valid),
    .i_addr  (i_cpu_addr),
    .o_bad   (bad_addr)                          // see R10 see R11
  );

  // option fields steering the watchdog and stop decoding
  // plain flop outputs, so they are safe to fan out widely
  assign o_watchdog_enable       = option_value[rcso_pkg::WATCHDOG_ENABLE_BIT]; // see R20
  assign o_watchdog_long_timeout = option_value[rcso_pkg::LONG_TIMEOUT_BIT];    // see R21
  assign o_stop_allow            = option_value[rcso_pkg::STOP_ALLOW_BIT];      // see R22

  // sources are taken as synchronous levels; a one-cycle pulse is enough
  // to start a reset, and a longer one is also recorded during the hold
  // qualified reset sources; a watchdog timeout while disabled is dropped
  always_comb begin
    src_pin       = !i_reset_pin_n;                                  // see R7
    src_watchdog  = i_watchdog_timeout && o_watchdog_enable;         // see R8
    src_opcode    = i_unimpl_opcode                                  // see R9
                    || (i_stop_instr && !o_stop_allow)               // see R22
                    || (i_enter_background_instr && !i_background_mode_allow);
    src_clock_gen = i_clock_gen_reset;                               // see R12
    src_brownout  = i_brownout_trip && i_brownout_reset_enable       // see R13
                    && i_brownout_stop_enable;
    any_source    = src_pin || src_watchdog || src_opcode || src_clock_gen
                    || src_brownout || bad_addr;
  end

  // flag pattern for the sources active in this cycle
  // the power-on bit is never set here; only the power-on reset sets it
  always_comb begin
    active_flags = rcso_pkg::READ_ZERO;
    active_flags[rcso_pkg::PIN_BIT]        = src_pin;        // see R6 see R7
    active_flags[rcso_pkg::WATCHDOG_BIT]   = src_watchdog;   // see R8
    active_flags[rcso_pkg::BAD_OPCODE_BIT] = src_opcode;     // see R9
    active_flags[rcso_pkg::BAD_ADDR_BIT]   = bad_addr;       // see R10
    active_flags[rcso_pkg::CLOCK_GEN_BIT]  = src_clock_gen;  // see R12
    active_flags[rcso_pkg::BROWNOUT_BIT]   = src_brownout;   // see R13
  end

  // a debug force is taken only from the debug port, never from the cpu
  // a one in the force bit starts a reset two edges later, a zero is ignored
  always_comb begin
    debug_force_nxt = 1'b0;
    if (dbg_force_wr) begin
      debug_force_nxt = i_debug_wdata[rcso_pkg::DEBUG_RESET_BIT];   // see R14 see R15
    end
  end

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      debug_force_r <= 1'b0;
    end else begin
      debug_force_r <= debug_force_nxt;
    end
  end

  // reset sequencer: hold the internal reset for a minimum time and
  // for as long as the external pin stays low
  // limitation: a pin held low forever keeps the device in reset, which
  // is intended, as the external reset owns the device while asserted
  always_comb begin
    state_nxt    = state_r;
    hold_cnt_nxt = hold_cnt_r;
    case (state_r)
      rcso_pkg::RCSO_RUN: begin
        if (any_source || debug_force_r) begin   // see R15
          state_nxt    = rcso_pkg::RCSO_HOLD;
          hold_cnt_nxt = 8'h00;
        end
      end
      rcso_pkg::RCSO_HOLD: begin
        if (hold_cnt_r != HOLD_LAST) begin
          hold_cnt_nxt = hold_cnt_r + 8'h01;
        // stay in hold while the pin is low or the supply is still tripped
        end else if (!src_pin && !src_brownout) begin
          state_nxt = rcso_pkg::RCSO_RUN;
        end
      end
      // an unknown state falls back into reset, the safe side
      default: begin
        state_nxt = rcso_pkg::RCSO_HOLD;
      end
    endcase
  end

  // power-on leaves the sequencer in hold so the device starts in reset
  // the counter restarts at zero on every entry, so back-to-back resets
  // each get the full minimum hold
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      state_r    <= rcso_pkg::RCSO_HOLD;
      hold_cnt_r <= 8'h00;
    end else begin
      state_r    <= state_nxt;
      hold_cnt_r <= hold_cnt_nxt;
    end
  end

  // internal reset straight from the state flop, free of decode glitches
  assign o_system_reset = (state_r == rcso_pkg::RCSO_HOLD);

  // status flags: rebuilt on entry to reset, added to while it lasts,
  // then frozen; bus writes never reach them
  // brownout is checked first so it keeps the power-on bit; other
  // sources firing in the same cycle are still recorded beside it
  always_comb begin
    status_nxt = status_r;                                    // see R3 see R23
    case (state_r)
      rcso_pkg::RCSO_RUN: begin
        if (src_brownout) begin
          status_nxt = active_flags;                          // see R5
          status_nxt[rcso_pkg::POWER_ON_BIT] = status_r[rcso_pkg::POWER_ON_BIT];
        end else if (any_source) begin
          status_nxt = active_flags;                          // see R6
        // a bare debug force leaves every flag clear
        end else if (debug_force_r) begin
          status_nxt = rcso_pkg::READ_ZERO;                   // see R2
        end
      end
      rcso_pkg::RCSO_HOLD: begin
        // sources still active during the hold are recorded too
        status_nxt = status_r | active_flags;                 // see R23
      end
      default: begin
        status_nxt = status_r;
      end
    endcase
  end

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      // only the power-on reset loads this pattern; internal resets never do
      status_r <= rcso_pkg::STATUS_POWER_ON;                  // see R4
    end else begin
      status_r <= status_nxt;
    end
  end

  // any write to the status address, from either port, kicks the watchdog
  // the written value is dropped on purpose: software cannot fake a cause
  // by writing the status address
  always_comb begin
    restart_nxt = 1'b0;
    if (cpu_status_wr) begin
      restart_nxt = 1'b1;                                     // see R3
    end else if (dbg_status_wr) begin
      restart_nxt = 1'b1;                                     // see R3
    end
  end

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      restart_r <= 1'b0;
    end else begin
      restart_r <= restart_nxt;
    end
  end

  // one-cycle pulse; the watchdog counter itself lives outside this block
  assign o_watchdog_restart = restart_r;

  // read path: registered data one cycle after the read, zero elsewhere
  // unmapped addresses give no hit, so software can tell them apart
  always_comb begin
    rdata_nxt = rcso_pkg::READ_ZERO;
    hit_nxt   = 1'b0;
    if (cpu_rd) begin
      if (i_cpu_addr == rcso_pkg::STATUS_ADDR) begin
        rdata_nxt = status_r;                                 // see R1
        hit_nxt   = 1'b1;
      end else if (i_cpu_addr == rcso_pkg::DEBUG_ADDR) begin
        rdata_nxt = rcso_pkg::READ_ZERO;                      // see R14
        hit_nxt   = 1'b1;
      end else if (i_cpu_addr == rcso_pkg::OPTION_ADDR) begin
        rdata_nxt = option_value & rcso_pkg::OPTION_IMPL_MASK; // see R17
        hit_nxt   = 1'b1;
      end
    end
  end

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      rdata_r <= rcso_pkg::READ_ZERO;
      hit_r   <= 1'b0;
    end else begin
      rdata_r <= rdata_nxt;
      hit_r   <= hit_nxt;
    end
  end

  // bus answer straight from flops
  assign o_cpu_rdata = rdata_r;
  assign o_cpu_hit   = hit_r;

endmodule

// ===== rcso_pkg.sv
// constants shared by the reset cause and system option block
package rcso_pkg;

  // register addresses on the cpu bus (high-page register space)
  localparam logic [15:0] STATUS_ADDR = 16'h1800;
  localparam logic [15:0] DEBUG_ADDR  = 16'h1801;
  localparam logic [15:0] OPTION_ADDR = 16'h1802;

  // illegal address windows
  localparam logic [15:0] GAP_LOW_FIRST  = 16'h0470;
  localparam logic [15:0] GAP_LOW_LAST   = 16'h17ff;
  localparam logic [15:0] GAP_HIGH_FIRST = 16'h1860;
  localparam logic [15:0] GAP_HIGH_LAST  = 16'hbfff;

  // reset cause status flag positions
  localparam int POWER_ON_BIT  = 7;
  localparam int PIN_BIT       = 6;
  localparam int WATCHDOG_BIT  = 5;
  localparam int BAD_OPCODE_BIT = 4;
  localparam int BAD_ADDR_BIT  = 3;
  localparam int CLOCK_GEN_BIT = 2;
  localparam int BROWNOUT_BIT  = 1;

  // option register field positions and defaults
  localparam int WATCHDOG_ENABLE_BIT = 7;
  localparam int LONG_TIMEOUT_BIT    = 6;
  localparam int STOP_ALLOW_BIT      = 5;
  localparam logic [7:0] OPTION_RESET    = 8'hc0;
  localparam logic [7:0] OPTION_IMPL_MASK = 8'hf3;

  // debug force reset control field
  localparam int DEBUG_RESET_BIT = 0;

  // status pattern after a power-on reset
  localparam logic [7:0] STATUS_POWER_ON = 8'h82;
  localparam logic [7:0] READ_ZERO       = 8'h00;

  // minimum time the internal reset is held asserted
  localparam int HOLD_TIME_NS    = 64;
  localparam int CLOCK_PERIOD_NS = 8;
  localparam int HOLD_CYCLES     = (HOLD_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

  // internal reset sequencer states
  typedef enum logic [0:0] {
    RCSO_RUN,
    RCSO_HOLD
  } rcso_state_t;

endpackage

// ===== rcso_once_reg.sv
// write-once option register, unlocked again by each system reset
`timescale 1ns/1ps
module rcso_once_reg #(
  parameter int         WIDTH     = 8,
  parameter logic [7:0] RESET_VAL = 8'h00
) (
  input  wire logic             i_clock,
  input  wire logic             i_reset,
  input  wire logic             i_sys_reset,
  input  wire logic             i_wr,
  input  wire logic [WIDTH-1:0] i_wdata,
  output logic      [WIDTH-1:0] o_value,
  output logic                  o_locked
);

  if (WIDTH < 1 || WIDTH > 8) begin : g_width_check
    $error("rcso_once_reg: WIDTH must be 1 to 8");
  end

  logic [WIDTH-1:0] value_r;
  logic [WIDTH-1:0] value_nxt;
  logic             locked_r;
  logic             locked_nxt;

  // first write after reset is taken, later ones are dropped
  always_comb begin
    value_nxt  = value_r;
    locked_nxt = locked_r;
    if (i_sys_reset) begin
      value_nxt  = RESET_VAL[WIDTH-1:0];
      locked_nxt = 1'b0;
    end else if (i_wr && !locked_r) begin
      value_nxt  = i_wdata;
      locked_nxt = 1'b1;
    end
  end

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      value_r  <= RESET_VAL[WIDTH-1:0];
      locked_r <= 1'b0;
    end else begin
      value_r  <= value_nxt;
      locked_r <= locked_nxt;
    end
  end

  assign o_value  = value_r;
  assign o_locked = locked_r;

endmodule

// ===== rcso_addr_guard.sv
// flags cpu accesses that fall into an unpopulated address gap
`timescale 1ns/1ps
module rcso_addr_guard (
  input  wire logic        i_clock,
  input  wire logic        i_reset,
  input  wire logic        i_valid,
  input  wire logic [15:0] i_addr,
  output logic             o_bad
);

  logic bad_r;
  logic bad_nxt;

  // register space itself is never illegal, only the two gaps are
  always_comb begin
    bad_nxt = 1'b0;
    if (i_valid) begin
      if (i_addr >= rcso_pkg::GAP_LOW_FIRST && i_addr <= rcso_pkg::GAP_LOW_LAST) begin
        bad_nxt = 1'b1;
      end else if (i_addr >= rcso_pkg::GAP_HIGH_FIRST
                   && i_addr <= rcso_pkg::GAP_HIGH_LAST) begin
        bad_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      bad_r <= 1'b0;
    end else begin
      bad_r <= bad_nxt;
    end
  end

  assign o_bad = bad_r;

endmodule

// ===== rcso_props.sv
// concurrent checks on the reset cause block ports
`timescale 1ns/1ps
module rcso_props #(
  parameter int HOLD_CYCLES = 8
) (
  input wire logic        i_clock,
  input wire logic        i_reset,
  input wire logic        i_cpu_valid,
  input wire logic        i_cpu_write,
  input wire logic [15:0] i_cpu_addr,
  input wire logic [7:0]  o_cpu_rdata,
  input wire logic        o_cpu_hit,
  input wire logic        i_reset_pin_n,
  input wire logic        i_watchdog_timeout,
  input wire logic        i_unimpl_opcode,
  input wire logic        o_system_reset,
  input wire logic        o_watchdog_restart,
  input wire logic        o_watchdog_enable,
  input wire logic        o_watchdog_long_timeout,
  input wire logic        o_stop_allow
);
  // qualified accesses; nothing is taken while the internal reset holds
  logic       run;
  logic       acc;
  logic       gap;
  logic [8:0] hold_r;
  assign run = !o_system_reset;
  assign acc = i_cpu_valid && run;
  assign gap = (i_cpu_addr >= rcso_pkg::GAP_LOW_FIRST && i_cpu_addr <= rcso_pkg::GAP_LOW_LAST)
            || (i_cpu_addr >= rcso_pkg::GAP_HIGH_FIRST && i_cpu_addr <= rcso_pkg::GAP_HIGH_LAST);
  // counts sampled reset cycles; starts at one since power-on already holds it
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) hold_r <= 9'h001;
    else hold_r <= o_system_reset ? hold_r + 9'h001 : 9'h000;
  end
  default clocking dcb @(posedge i_clock); endclocking
  default disable iff (i_reset);
  property p_restart;
    acc && i_cpu_write && i_cpu_addr == rcso_pkg::STATUS_ADDR |=> o_watchdog_restart;
  endproperty
  a_restart: assert property (p_restart) else $error("status write gave no restart");
  property p_pin;
    !i_reset_pin_n && run |=> o_system_reset;
  endproperty
  a_pin: assert property (p_pin) else $error("low pin gave no reset");
  property p_wdog;
    i_watchdog_timeout && o_watchdog_enable && run |=> o_system_reset;
  endproperty
  a_wdog: assert property (p_wdog) else $error("timeout gave no reset");
  property p_opcode;
    i_unimpl_opcode && run |=> o_system_reset;
  endproperty
  a_opcode: assert property (p_opcode) else $error("bad opcode gave no reset");
  property p_gap;
    acc && gap |-> ##2 o_system_reset;
  endproperty
  a_gap: assert property (p_gap) else $error("gap access gave no reset");
  property p_dbg_read;
    acc && !i_cpu_write && i_cpu_addr == rcso_pkg::DEBUG_ADDR |=> o_cpu_hit && o_cpu_rdata == 8'h00;
  endproperty
  a_dbg_read: assert property (p_dbg_read) else $error("debug register read not zero");
  property p_hold;
    $fell(o_system_reset) |-> hold_r >= HOLD_CYCLES;
  endproperty
  a_hold: assert property (p_hold) else $error("internal reset too short");
  property p_defaults;
    $fell(o_system_reset) |-> o_watchdog_enable && o_watchdog_long_timeout && !o_stop_allow;
  endproperty
  a_defaults: assert property (p_defaults) else $error("options not at defaults");
endmodule
bind rcso_top rcso_props #(.HOLD_CYCLES(HOLD_CYCLES)) u_props (.*);

// ===== rcso_dbg_host.sv
// background debug host model issuing single byte memory writes
`timescale 1ns/1ps
module rcso_dbg_host (
  input  wire logic        i_clock,
  output logic             o_debug_write,
  output logic      [15:0] o_debug_addr,
  output logic      [7:0]  o_debug_wdata
);
  initial begin
    o_debug_write = 1'b0;
    o_debug_addr  = 16'h5a5a;
    o_debug_wdata = 8'ha5;
  end
  // one write command per call; lines show junk once released, never stale data
  task automatic write_byte(input logic [15:0] a, input logic [7:0] d);
    @(negedge i_clock);
    o_debug_write = 1'b1;
    o_debug_addr  = a;
    o_debug_wdata = d;
    @(negedge i_clock);
    o_debug_write = 1'b0;
    o_debug_addr  = ~a;
    o_debug_wdata = ~d;
  endtask
endmodule

// ===== rcso_bench.sv
// self-checking bench for the reset cause and system option block
`timescale 1ns/1ps
module rcso_bench;
  localparam logic [15:0] SA = rcso_pkg::STATUS_ADDR;
  localparam logic [15:0] DA = rcso_pkg::DEBUG_ADDR;
  localparam logic [15:0] OA = rcso_pkg::OPTION_ADDR;
  logic        i_clock = 1'b0;
  logic        i_reset, i_cpu_valid, i_cpu_write, i_reset_pin_n, i_watchdog_timeout;
  logic        i_unimpl_opcode, i_stop_instr, i_enter_background_instr, i_debug_write;
  logic        i_background_mode_allow, i_clock_gen_reset, i_brownout_trip;
  logic        i_brownout_reset_enable, i_brownout_stop_enable, o_cpu_hit, o_stop_allow;
  logic        o_system_reset, o_watchdog_restart, o_watchdog_enable, o_watchdog_long_timeout;
  logic [15:0] i_cpu_addr, i_debug_addr;
  logic [7:0]  i_cpu_wdata, i_debug_wdata, o_cpu_rdata, r;
  int          num_errors = 0;
  int          n_tests    = 0;
  int          pos[6] = '{rcso_pkg::PIN_BIT, rcso_pkg::WATCHDOG_BIT, rcso_pkg::BAD_OPCODE_BIT,
                          rcso_pkg::BAD_OPCODE_BIT, rcso_pkg::BAD_OPCODE_BIT, rcso_pkg::CLOCK_GEN_BIT};
  rcso_top u_dut (.*);
  rcso_dbg_host u_host (.i_clock, .o_debug_write(i_debug_write), .o_debug_addr(i_debug_addr),
                        .o_debug_wdata(i_debug_wdata));
  // 125 MHz clock
  always #4 i_clock = ~i_clock;
  task automatic close_out();
    $display("errors %0d comparisons %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one register access, held across one sampling edge; read data kept in r
  task automatic cpu(input logic w, input logic [15:0] a, input logic [7:0] d);
    @(negedge i_clock);
    i_cpu_valid = 1'b1;
    i_cpu_write = w;
    i_cpu_addr  = a;
    i_cpu_wdata = d;
    @(negedge i_clock);
    i_cpu_valid = 1'b0;
    r = o_cpu_rdata;
  endtask
  task automatic rd_chk(input logic [15:0] a, input logic [7:0] e, input logic h);
    cpu(1'b0, a, 8'h00);
    chk(r, e);
    chk({7'h00, o_cpu_hit}, {7'h00, h});
  endtask
  task automatic set_src(input int i, input logic v);
    case (i)
      0: i_reset_pin_n = ~v;
      1: i_watchdog_timeout = v;
      2: i_unimpl_opcode = v;
      3: i_stop_instr = v;
      4: i_enter_background_instr = v;
      5: i_clock_gen_reset = v;
      default: i_brownout_trip = v;
    endcase
  endtask
  task automatic fire(input int i);
    @(negedge i_clock);
    set_src(i, 1'b1);
    @(negedge i_clock);
    set_src(i, 1'b0);
  endtask
  // bounded wait for the internal reset to let go
  task automatic run_wait();
    int k;
    k = 0;
    while (o_system_reset !== 1'b0 && k < 60) begin
      @(negedge i_clock);
      k++;
    end
    if (k == 60) num_errors++;
  endtask
  task automatic expect_reset(input logic e);
    logic seen;
    seen = 1'b0;
    repeat (3) begin
      @(negedge i_clock);
      seen = seen | o_system_reset;
    end
    chk({7'h00, seen}, {7'h00, e});
    run_wait();
  endtask
  task automatic t_por();
    rd_chk(SA, rcso_pkg::STATUS_POWER_ON, 1'b1);
    rd_chk(OA, rcso_pkg::OPTION_RESET, 1'b1);
    rd_chk(DA, rcso_pkg::READ_ZERO, 1'b1);
    rd_chk(16'h1803, 8'h00, 1'b0);
  endtask
  task automatic t_status_wr();
    cpu(1'b1, SA, 8'hff);
    chk({7'h00, o_watchdog_restart}, 8'h01);
    rd_chk(SA, rcso_pkg::STATUS_POWER_ON, 1'b1);
  endtask
  task automatic t_brown(input logic [7:0] e);
    i_brownout_reset_enable = 1'b1;
    i_brownout_stop_enable  = 1'b1;
    fire(6);
    expect_reset(1'b1);
    rd_chk(SA, e, 1'b1);
  endtask
  // each source alone must leave exactly its own flag
  task automatic t_sources();
    for (int i = 0; i < 6; i++) begin
      fire(i);
      expect_reset(1'b1);
      rd_chk(SA, 8'h01 << pos[i], 1'b1);
    end
  endtask
  task automatic t_gaps();
    logic [15:0] bad[4] = '{16'h0470, 16'h17ff, 16'h1860, 16'hbfff};
    for (int i = 0; i < 4; i++) begin
      cpu(1'b0, bad[i], 8'h00);
      expect_reset(1'b1);
      rd_chk(SA, 8'h01 << rcso_pkg::BAD_ADDR_BIT, 1'b1);
    end
    cpu(1'b0, 16'h185f, 8'h00);
    expect_reset(1'b0);
    cpu(1'b1, 16'hc000, 8'h00);
    expect_reset(1'b0);
  endtask
  task automatic t_debug();
    cpu(1'b1, DA, 8'h01);
    expect_reset(1'b0);
    u_host.write_byte(DA, 8'h00);
    expect_reset(1'b0);
    u_host.write_byte(DA, 8'h01);
    expect_reset(1'b1);
    rd_chk(SA, 8'h00, 1'b1);
    u_host.write_byte(SA, 8'h00);
    chk({7'h00, o_watchdog_restart}, 8'h01);
  endtask
  // lock the options, then try each blocked source before a reset unlocks them
  task automatic t_option();
    cpu(1'b1, OA, 8'h2f);
    cpu(1'b1, OA, 8'hff);
    rd_chk(OA, 8'h23, 1'b1);
    chk({5'h00, o_watchdog_enable, o_watchdog_long_timeout, o_stop_allow}, 8'h01);
    fire(3);
    expect_reset(1'b0);
    fire(1);
    expect_reset(1'b0);
    i_background_mode_allow = 1'b1;
    fire(4);
    expect_reset(1'b0);
    i_brownout_stop_enable = 1'b0;
    fire(6);
    expect_reset(1'b0);
    fire(5);
    expect_reset(1'b1);
    rd_chk(OA, rcso_pkg::OPTION_RESET, 1'b1);
  endtask
  // main sequence
  initial begin
    i_reset = 1'b1;
    i_cpu_valid = 1'b0;
    i_cpu_write = 1'b0;
    i_cpu_addr = 16'h0000;
    i_cpu_wdata = 8'h00;
    for (int i = 0; i < 7; i++) set_src(i, 1'b0);
    i_background_mode_allow = 1'b0;
    i_brownout_reset_enable = 1'b0;
    i_brownout_stop_enable = 1'b0;
    repeat (10) @(negedge i_clock);
    i_reset = 1'b0;
    run_wait();
    t_por();
    t_status_wr();
    t_brown(rcso_pkg::STATUS_POWER_ON);
    t_sources();
    t_brown(8'h01 << rcso_pkg::BROWNOUT_BIT);
    t_gaps();
    t_debug();
    t_option();
    close_out();
  end
  // hang guard, far beyond the roughly 250 cycles the sequence needs
  initial begin
    #32000;
    num_errors++;
    close_out();
  end
endmodule
